// ===== logic/fbp_regs.svh
// Register offsets, field positions, reset values and mode codes
`ifndef FBP_REGS_SVH
`define FBP_REGS_SVH
`define FBP_ADDR_W 2
`define FBP_ADDR_DOUT 2'h0
`define FBP_ADDR_PSTATE 2'h1
`define FBP_ADDR_DIR 2'h2
`define FBP_ADDR_CTRL 2'h3
`define FBP_NPIN 5
`define FBP_PIN_MSB 4
`define FBP_RSV_MSB 7
`define FBP_RSV_LSB 5
`define FBP_PIN4 4
`define FBP_PIN3 3
`define FBP_PIN2 2
`define FBP_PIN1 1
`define FBP_PIN0 0
`define FBP_CS0 0
`define FBP_CS1 1
`define FBP_CS2 2
`define FBP_CS3 3
`define FBP_CTRL_TRG_LO 0
`define FBP_CTRL_TRG_HI 1
`define FBP_CTRL_KEEP 2
`define FBP_DOUT_RST 5'h00
`define FBP_DIR_RST_CS0 5'h10
`define FBP_DIR_RST_NONE 5'h00
`define FBP_CTRL_RST 3'h0
`define FBP_RSV_READ 3'h0
`define FBP_INIT_WAIT 2'h3
`define FBP_MODE_1 3'h1
`define FBP_MODE_2 3'h2
`define FBP_MODE_4 3'h4
`define FBP_MODE_5 3'h5
`define FBP_MODE_6 3'h6
`define FBP_SYNC_W 8
`endif

// ===== logic/fbp_pkg.sv
// Types shared by the five-bit port logic
package fbp_pkg;
   // Whole state of the port, registered as one word
   typedef struct packed {
      logic [4:0] dout;       // Output data bits
      logic [4:0] dir;        // Direction bits, 1 = output
      logic [2:0] ctrl;       // Trigger select and standby keep
      logic [4:0] pstate;     // Pin-state view
      logic [2:0] mode;       // Captured operating mode
      logic [1:0] init_cnt;   // Settling count before mode init
      logic [4:0] pin_o;      // Pin output levels
      logic [4:0] pin_oe;     // Pin output enables
      logic ext_interrupt_6;             // Pin 0 toward interrupt 6
      logic ext_interrupt_7;             // Pin 1 toward interrupt 7
      logic trig;             // Pin 0 toward converter trigger
      logic [7:0] rdata;      // Read answer
   } fbp_state_t;
endpackage

// ===== logic/fbp_sync.sv
// Two-stage synchroniser for pin and strap levels
`timescale 1ns/1ps
`include "fbp_regs.svh"
module fbp_sync #(
   parameter int W = `FBP_SYNC_W
) (
   input wire logic CLK_IN,            // System clock
   input wire logic RSTN_IN,           // Async reset, active low
   input wire logic [W-1:0] D_IN,      // Asynchronous levels
   output logic [W-1:0] Q_OUT          // Synchronised levels
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // One pair of flops per bit; only the second stage is read
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
            if (!RSTN_IN) begin
               meta_q[i] <= 1'b0;
               sync_q[i] <= 1'b0;
            end else begin
               meta_q[i] <= D_IN[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   assign Q_OUT = sync_q;
endmodule // fbp_sync

// ===== logic/fbp_port.sv
// Five-bit general-purpose port with chip-select, interrupt, trigger use
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "fbp_regs.svh"
module fbp_port
   import fbp_pkg::*;
(
   input wire logic CLK_IN,              // System clock, 125 MHz
   input wire logic RSTN_IN,             // Power-on reset, active low
   input wire logic HW_STBY_IN,          // Hardware standby, high
   input wire logic MAN_RST_IN,          // Manual reset, high
   input wire logic SW_STBY_IN,          // Software standby, high
   input wire logic [2:0] MODE_IN,       // Operating mode strap pins
   input wire logic [`FBP_ADDR_W-1:0] ADDR_IN,  // Register address
   input wire logic [7:0] WDATA_IN,      // Write data
   input wire logic WR_IN,               // Write strobe
   input wire logic RD_IN,               // Read strobe
   input wire logic [3:0] CS_IN,         // Chip-selects from bus logic
   input wire logic [4:0] PIN_IN,        // Pin levels as seen on pads
   output logic [7:0] RDATA_OUT,         // Read data, cycle after read
   output logic [4:0] PIN_OUT,           // Pin drive levels
   output logic [4:0] PIN_OE_OUT,        // Pin drive enables
   output logic EXT_INT6_OUT,            // Level toward interrupt 6
   output logic EXT_INT7_OUT,            // Level toward interrupt 7
   output logic CONV_TRIG_OUT            // Level toward converter
);
   fbp_state_t s_q;
   fbp_state_t s_d;
   logic [`FBP_SYNC_W-1:0] sync_w;
   logic [4:0] pin_s;
   logic [2:0] mode_s;
   logic cs0_mode;
   logic csx_mode;
   logic init_done;
   logic freeze;
   logic cs_hiz;
   logic [4:0] cs_use;
   logic [4:0] cs_lvl;

   // Pins and strap pass two flops before use
   fbp_sync #(
      .W(`FBP_SYNC_W)
   ) u_sync (
      .CLK_IN(CLK_IN),
      .RSTN_IN(RSTN_IN),
      .D_IN({MODE_IN, PIN_IN}),
      .Q_OUT(sync_w)
   );

   assign pin_s = sync_w[4:0];
   assign mode_s = sync_w[7:5];

   // Mode decode from the captured mode
   assign cs0_mode = (s_q.mode == `FBP_MODE_1) ||
                     (s_q.mode == `FBP_MODE_2) ||
                     (s_q.mode == `FBP_MODE_4) ||
                     (s_q.mode == `FBP_MODE_5) ||
                     (s_q.mode == `FBP_MODE_6);
   assign csx_mode = (s_q.mode == `FBP_MODE_4) ||
                     (s_q.mode == `FBP_MODE_5) ||
                     (s_q.mode == `FBP_MODE_6);
   assign init_done = (s_q.init_cnt == `FBP_INIT_WAIT);
   assign freeze = MAN_RST_IN || SW_STBY_IN;
   assign cs_hiz = SW_STBY_IN && !s_q.ctrl[`FBP_CTRL_KEEP];

   // Which pins act as chip-selects, and the level each one drives
   assign cs_use = {cs0_mode, csx_mode, csx_mode, csx_mode, 1'b0};
   assign cs_lvl = {CS_IN[`FBP_CS0], CS_IN[`FBP_CS1], CS_IN[`FBP_CS2],
                    CS_IN[`FBP_CS3], 1'b0};

   // Next-state logic for the whole port
   always_comb begin
      logic [4:0] ps_view;
      logic [4:0] is_cs;
      ps_view = 5'h00;
      is_cs = 5'h00;
      s_d = s_q;
      s_d.rdata = 8'h00;
      // Pin-state view mixes data bits and pin levels
      ps_view = (s_q.dir & s_q.dout) | (~s_q.dir & pin_s);
      // Count settling cycles, then apply mode-dependent direction
      if (!init_done) begin
         s_d.init_cnt = s_q.init_cnt + 2'h1;
      end
      if (s_q.init_cnt == `FBP_INIT_WAIT - 2'h1) begin
         s_d.mode = mode_s;
         if ((mode_s == `FBP_MODE_1) || (mode_s == `FBP_MODE_4) ||
             (mode_s == `FBP_MODE_5)) begin
            s_d.dir = `FBP_DIR_RST_CS0;
         end else begin
            s_d.dir = `FBP_DIR_RST_NONE;
         end
      end
      // Pin-state follows the view unless held
      if (!freeze) begin
         s_d.pstate = ps_view;
      end
      // Register writes; pin-state address takes none
      if (WR_IN && init_done && !HW_STBY_IN) begin
         unique case (ADDR_IN)
            `FBP_ADDR_DOUT: s_d.dout = WDATA_IN[4:0];
            `FBP_ADDR_PSTATE: s_d.dout = s_q.dout;
            `FBP_ADDR_DIR: s_d.dir = WDATA_IN[4:0];
            `FBP_ADDR_CTRL: s_d.ctrl = WDATA_IN[2:0];
         endcase
      end
      // Read answer; reserved bits read zero
      if (RD_IN) begin
         unique case (ADDR_IN)
            `FBP_ADDR_DOUT: s_d.rdata = {`FBP_RSV_READ, s_q.dout};
            `FBP_ADDR_PSTATE: s_d.rdata = {`FBP_RSV_READ, s_q.pstate};
            `FBP_ADDR_DIR: s_d.rdata = 8'h00;
            `FBP_ADDR_CTRL: s_d.rdata = {5'h00, s_q.ctrl};
         endcase
      end
      // Hardware standby clears data and restarts mode init
      if (HW_STBY_IN) begin
         s_d.dout = `FBP_DOUT_RST;
         s_d.dir = `FBP_DIR_RST_NONE;
         s_d.init_cnt = 2'h0;
      end
      // Pin function per bit: chip-select, port output or input
      is_cs = cs_use & s_q.dir;
      s_d.pin_o = (is_cs & cs_lvl) | (~is_cs & s_q.dout);
      s_d.pin_oe = s_q.dir & ~(is_cs & {5{cs_hiz}});
      if (HW_STBY_IN || !init_done) begin
         s_d.pin_oe = 5'h00;
      end
      // Interrupt and trigger feeds from synchronised pins
      s_d.ext_interrupt_7 = pin_s[`FBP_PIN1];
      s_d.ext_interrupt_6 = pin_s[`FBP_PIN0];
      s_d.trig = pin_s[`FBP_PIN0] && s_q.ctrl[`FBP_CTRL_TRG_HI] &&
                 s_q.ctrl[`FBP_CTRL_TRG_LO];
   end

   // State register; only power-on reset clears it
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign RDATA_OUT = s_q.rdata;
   assign PIN_OUT = s_q.pin_o;
   assign PIN_OE_OUT = s_q.pin_oe;
   assign EXT_INT6_OUT = s_q.ext_interrupt_6;
   assign EXT_INT7_OUT = s_q.ext_interrupt_7;
   assign CONV_TRIG_OUT = s_q.trig;

   // Checks on the port behaviour
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RSTN_IN);

   AST_DOUT_WRITE: assert property (
      WR_IN && ADDR_IN == `FBP_ADDR_DOUT && init_done && !HW_STBY_IN
      |=> s_q.dout == $past(WDATA_IN[4:0]) && RDATA_OUT == 8'h00)
      else $error("output data write not stored");

   AST_RSV_READ: assert property (
      RD_IN |=> RDATA_OUT[7:5] == `FBP_RSV_READ)
      else $error("reserved bits read nonzero");

   AST_HWSTBY_CLEAR: assert property (
      HW_STBY_IN |=> s_q.dout == `FBP_DOUT_RST && PIN_OE_OUT == 5'h00)
      else $error("hardware standby did not clear data");

   AST_MANRST_KEEP: assert property (
      MAN_RST_IN && !WR_IN && !HW_STBY_IN |=> $stable(s_q.dout))
      else $error("manual reset changed output data");

   AST_PS_NOWRITE: assert property (
      WR_IN && ADDR_IN == `FBP_ADDR_PSTATE && !HW_STBY_IN && init_done
      |=> $stable(s_q.dout) && $stable(s_q.dir))
      else $error("pin-state write changed a register");

   AST_PS_READ: assert property (
      !freeze ##1 RD_IN && ADDR_IN == `FBP_ADDR_PSTATE
      |=> RDATA_OUT[4:0] == $past(s_q.pstate))
      else $error("pin-state read mismatch");

   AST_PS_MIX: assert property (
      !freeze |=> s_q.pstate == (($past(s_q.dir) & $past(s_q.dout)) |
                                 (~$past(s_q.dir) & $past(pin_s))))
      else $error("pin-state view wrong");

   AST_PS_HOLD: assert property (
      freeze |=> $stable(s_q.pstate))
      else $error("pin-state changed while held");

   AST_DIR_INIT: assert property (
      s_q.init_cnt == `FBP_INIT_WAIT - 2'h1 && !HW_STBY_IN &&
      mode_s == `FBP_MODE_4 |=> s_q.dir == `FBP_DIR_RST_CS0)
      else $error("direction init wrong for chip-select mode");

   AST_CS0_DRIVE: assert property (
      init_done && !HW_STBY_IN && cs0_mode && s_q.dir[`FBP_PIN4] && !cs_hiz
      |=> PIN_OUT[`FBP_PIN4] == $past(CS_IN[`FBP_CS0]) &&
          PIN_OE_OUT[`FBP_PIN4])
      else $error("pin 4 not driving chip-select 0");

   AST_CS3_DRIVE: assert property (
      init_done && !HW_STBY_IN && csx_mode && s_q.dir[`FBP_PIN1] && !cs_hiz
      |=> PIN_OUT[`FBP_PIN1] == $past(CS_IN[`FBP_CS3]))
      else $error("pin 1 not driving chip-select 3");

   AST_GPIO_MODE: assert property (
      !csx_mode && s_q.dir[`FBP_PIN3]
      |=> PIN_OUT[`FBP_PIN3] == $past(s_q.dout[`FBP_PIN3]))
      else $error("pin 3 not plain port in this mode");

   AST_STBY_HIZ: assert property (
      cs_hiz && csx_mode |=> PIN_OE_OUT[3:1] == 3'h0)
      else $error("chip-select driven in standby without keep");

   AST_OE_INPUT: assert property (
      s_q.dir == 5'h00 |=> PIN_OE_OUT == 5'h00)
      else $error("driver on for an input pin");

   AST_IRQ_FEED: assert property (
      $past(RSTN_IN, 3) |->
      (EXT_INT7_OUT == $past(PIN_IN[`FBP_PIN1], 3) &&
       EXT_INT6_OUT == $past(PIN_IN[`FBP_PIN0], 3)))
      else $error("interrupt feed not three cycles behind pin");

   AST_TRIG_GATE: assert property (
      !(s_q.ctrl[`FBP_CTRL_TRG_HI] && s_q.ctrl[`FBP_CTRL_TRG_LO])
      |=> !CONV_TRIG_OUT)
      else $error("trigger passed while not selected");

   // Register access checks
   AST_DIR_WRITE: assert property (
      WR_IN && ADDR_IN == `FBP_ADDR_DIR && init_done && !HW_STBY_IN
      |=> s_q.dir == $past(WDATA_IN[4:0]))
      else $error("direction write not stored");

   AST_CTRL_WRITE: assert property (
      WR_IN && ADDR_IN == `FBP_ADDR_CTRL && init_done && !HW_STBY_IN
      |=> s_q.ctrl == $past(WDATA_IN[2:0]))
      else $error("control write not stored");

   AST_DOUT_READ: assert property (
      RD_IN && ADDR_IN == `FBP_ADDR_DOUT
      |=> RDATA_OUT[4:0] == $past(s_q.dout))
      else $error("output data read mismatch");

   AST_DIR_READ: assert property (
      RD_IN && ADDR_IN == `FBP_ADDR_DIR |=> RDATA_OUT == 8'h00)
      else $error("direction read not zero");

   AST_RDATA_IDLE: assert property (
      !RD_IN |=> RDATA_OUT == 8'h00)
      else $error("read data not zero outside a read");

   AST_INIT_NOWRITE: assert property (
      WR_IN && !init_done && !HW_STBY_IN |=> $stable(s_q.dout))
      else $error("write accepted during mode init");

   AST_HWSTBY_INIT: assert property (
      HW_STBY_IN
      |=> s_q.init_cnt == 2'h0 && s_q.dir == `FBP_DIR_RST_NONE)
      else $error("hardware standby did not restart mode init");

   AST_MANRST_DIR: assert property (
      MAN_RST_IN && init_done && !WR_IN && !HW_STBY_IN |=> $stable(s_q.dir))
      else $error("manual reset changed direction");

   AST_SWSTBY_KEEP: assert property (
      SW_STBY_IN && init_done && !WR_IN && !HW_STBY_IN
      |=> $stable(s_q.dout) && $stable(s_q.dir))
      else $error("software standby changed data or direction");

   // Pin drive and converter trigger checks
   AST_INIT_OE_OFF: assert property (
      !init_done |=> PIN_OE_OUT == 5'h00)
      else $error("driver on before mode init");

   AST_OE_DIR: assert property (
      init_done && !HW_STBY_IN && !cs_hiz
      |=> PIN_OE_OUT == $past(s_q.dir))
      else $error("drivers do not follow direction");

   AST_CS_KEEP: assert property (
      SW_STBY_IN && s_q.ctrl[`FBP_CTRL_KEEP] && init_done && !HW_STBY_IN
      |=> PIN_OE_OUT == $past(s_q.dir))
      else $error("chip-select floated although keep set");

   AST_CS1_DRIVE: assert property (
      init_done && !HW_STBY_IN && csx_mode && s_q.dir[`FBP_PIN3] && !cs_hiz
      |=> PIN_OUT[`FBP_PIN3] == $past(CS_IN[`FBP_CS1]) &&
          PIN_OE_OUT[`FBP_PIN3])
      else $error("pin 3 not driving chip-select 1");

   AST_CS2_DRIVE: assert property (
      init_done && !HW_STBY_IN && csx_mode && s_q.dir[`FBP_PIN2] && !cs_hiz
      |=> PIN_OUT[`FBP_PIN2] == $past(CS_IN[`FBP_CS2]) &&
          PIN_OE_OUT[`FBP_PIN2])
      else $error("pin 2 not driving chip-select 2");

   AST_PIN4_GPIO: assert property (
      !cs0_mode && s_q.dir[`FBP_PIN4]
      |=> PIN_OUT[`FBP_PIN4] == $past(s_q.dout[`FBP_PIN4]))
      else $error("pin 4 not plain port in this mode");

   AST_PIN1_GPIO: assert property (
      !csx_mode && s_q.dir[`FBP_PIN1]
      |=> PIN_OUT[`FBP_PIN1] == $past(s_q.dout[`FBP_PIN1]))
      else $error("pin 1 not plain port in this mode");

   AST_PIN0_GPIO: assert property (
      s_q.dir[`FBP_PIN0]
      |=> PIN_OUT[`FBP_PIN0] == $past(s_q.dout[`FBP_PIN0]))
      else $error("pin 0 not driving output data");

   AST_TRIG_PASS: assert property (
      s_q.ctrl[`FBP_CTRL_TRG_HI] && s_q.ctrl[`FBP_CTRL_TRG_LO]
      |=> CONV_TRIG_OUT == $past(pin_s[`FBP_PIN0]))
      else $error("trigger not following pin 0 while selected");

   COV_CS_KEEP: cover property (SW_STBY_IN && s_q.ctrl[`FBP_CTRL_KEEP]);
   COV_CS_MODE: cover property (
      csx_mode && s_q.dir[`FBP_PIN2] ##1 PIN_OE_OUT[`FBP_PIN2]);
   COV_PS_READ_PIN: cover property (
      RD_IN && ADDR_IN == `FBP_ADDR_PSTATE && s_q.dir == 5'h00);
   COV_STBY_HIZ: cover property (cs_hiz && s_q.dir[`FBP_PIN4]);
   COV_TRIG: cover property (CONV_TRIG_OUT);
endmodule // fbp_port

// ===== verification/fbp_board.sv
// Board-side model of the five port pads with pull-ups
`timescale 1ns/1ps
module fbp_board (
   input wire logic [4:0] PIN_IN,     // Levels the port drives
   input wire logic [4:0] PIN_OE_IN,  // Port drive enables
   input wire logic [4:0] DRV_EN_IN,  // Board drives the pad
   input wire logic [4:0] DRV_IN,     // Board drive levels
   output logic [4:0] PAD_OUT         // Resolved pad levels
);
   // Port driver wins, then the board; an undriven pad is pulled high
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         PAD_OUT[i] = PIN_OE_IN[i] ? PIN_IN[i] :
                      (DRV_EN_IN[i] ? DRV_IN[i] : 1'b1);
      end
   end
endmodule // fbp_board

// ===== verification/fbp_port_bench.sv
// Self-checking bench for the five-bit port
`timescale 1ns/1ps
`include "fbp_regs.svh"
module fbp_port_bench;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic hw_stby = 1'b0;
   logic man_rst = 1'b0;
   logic sw_stby = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic pend = 1'b0;
   logic [2:0] mode = 3'h3;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic [3:0] cs = 4'hF;
   logic [4:0] drv_en = 5'h1F;
   logic [4:0] drv = 5'h00;
   logic [7:0] rdata;
   logic [4:0] pad, pin_o, oe, d, dr, v, k;
   logic int6, int7, trig;
   logic [7:0] exp_q[$];
   int mismatches = 0;
   int checks_done = 0;
   int seed = 78;

   fbp_port u_dut (.CLK_IN(clk), .RSTN_IN(rstn), .HW_STBY_IN(hw_stby),
      .MAN_RST_IN(man_rst), .SW_STBY_IN(sw_stby), .MODE_IN(mode),
      .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
      .CS_IN(cs), .PIN_IN(pad), .RDATA_OUT(rdata), .PIN_OUT(pin_o),
      .PIN_OE_OUT(oe), .EXT_INT6_OUT(int6), .EXT_INT7_OUT(int7),
      .CONV_TRIG_OUT(trig));

   fbp_board u_board (.PIN_IN(pin_o), .PIN_OE_IN(oe), .DRV_EN_IN(drv_en),
      .DRV_IN(drv), .PAD_OUT(pad));

   // 125 MHz clock
   always #4 clk = ~clk;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("mismatches %0d checks %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Read data stand in the cycle after the strobe
   always @(negedge clk) begin
      if (pend) begin
         chk(rdata, exp_q.pop_front());
      end
      pend = rd;
   end

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] x);
      @(posedge clk);
      addr <= a;
      wdata <= x;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [1:0] a, input logic [7:0] x);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(x);
      @(posedge clk);
      rd <= 1'b0;
   endtask

   task automatic reset_to(input logic [2:0] m);
      @(posedge clk);
      rstn <= 1'b0;
      mode <= m;
      cs <= 4'($random(seed));
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      results();
   end

   initial begin
      // Reset direction and chip-select 0 in every mode
      for (int m = 0; m < 8; m++) begin
         reset_to(3'(m));
         settle(8);
         k = (m == 1 || m == 4 || m == 5) ? 5'h10 : 5'h00;
         chk(8'(oe), 8'(k));
         chk(8'(pin_o & k), 8'({cs[0], 4'h0} & k));
      end
      reset_to(3'h3);
      settle(4);
      rd_reg(`FBP_ADDR_DOUT, 8'h00);
      d = 5'($random(seed));
      wr_reg(`FBP_ADDR_DOUT, {3'h7, d});
      rd_reg(`FBP_ADDR_DOUT, 8'(d));
      wr_reg(`FBP_ADDR_PSTATE, {3'h7, ~d});
      rd_reg(`FBP_ADDR_DOUT, 8'(d));
      rd_reg(`FBP_ADDR_DIR, 8'h00);
      // Driven bits read back data, the others the pad
      repeat (4) begin
         dr = 5'($random(seed));
         v = 5'($random(seed));
         @(posedge clk);
         drv_en <= ~dr;
         drv <= v;
         wr_reg(`FBP_ADDR_DIR, 8'(dr));
         settle(6);
         chk(8'(oe), 8'(dr));
         chk(8'(pin_o & dr), 8'(d & dr));
         rd_reg(`FBP_ADDR_PSTATE, 8'(dr & d | ~dr & v));
      end
      @(posedge clk);
      drv_en <= 5'h1F;
      wr_reg(`FBP_ADDR_DIR, 8'h00);
      // Interrupt and trigger feeds for all pin and select pairs
      for (int c = 0; c < 16; c++) begin
         @(posedge clk);
         drv <= 5'(c & 3);
         wr_reg(`FBP_ADDR_CTRL, 8'(c >> 2));
         settle(6);
         chk(8'(int6), 8'(c[0]));
         chk(8'(int7), 8'(c[1]));
         chk(8'(trig), 8'(c[0] & c[2] & c[3]));
      end
      // Manual reset, then software standby, freeze the pin view
      for (int s = 0; s < 2; s++) begin
         v = 5'($random(seed));
         @(posedge clk);
         drv <= v;
         settle(6);
         @(posedge clk);
         man_rst <= (s == 0);
         sw_stby <= (s == 1);
         drv <= ~v;
         settle(6);
         rd_reg(`FBP_ADDR_PSTATE, 8'(v));
         rd_reg(`FBP_ADDR_DOUT, 8'(d));
         @(posedge clk);
         man_rst <= 1'b0;
         sw_stby <= 1'b0;
      end
      // Hardware standby clears data and direction
      wr_reg(`FBP_ADDR_DIR, 8'h1F);
      @(posedge clk);
      hw_stby <= 1'b1;
      settle(2);
      chk(8'(oe), 8'h00);
      @(posedge clk);
      hw_stby <= 1'b0;
      settle(6);
      rd_reg(`FBP_ADDR_DOUT, 8'h00);
      rd_reg(`FBP_ADDR_PSTATE, {3'h0, ~v});
      // Mode 4: pins 4..1 carry chip-selects 0..3
      reset_to(3'h4);
      settle(4);
      wr_reg(`FBP_ADDR_DIR, 8'h1F);
      wr_reg(`FBP_ADDR_DOUT, 8'h01);
      repeat (4) begin
         @(posedge clk);
         cs <= 4'($random(seed));
         settle(3);
         chk(8'(oe), 8'h1F);
         chk(8'(pin_o), 8'({cs[0], cs[1], cs[2], cs[3], 1'b1}));
      end
      // Standby floats chip-selects unless the keep bit is set
      for (int j = 0; j < 2; j++) begin
         wr_reg(`FBP_ADDR_CTRL, 8'(4 * j));
         @(posedge clk);
         sw_stby <= 1'b1;
         settle(3);
         chk(8'(oe), (j == 1) ? 8'h1F : 8'h01);
         @(posedge clk);
         sw_stby <= 1'b0;
      end
      settle(3);
      results();
   end
endmodule // fbp_port_bench
